// ==== hw/hvf_pkg.sv ====
// Constants and types of the heavy-vehicle CAN request formatter.
// Notes on behaviour
// - Heavy protocol bit rate defaults to 250 kbps; a stored parameter replaces it.
// - Two user CAN protocol selections may enable heavy-vehicle formatting by parameter.
// - Frames use 29-bit identifiers and carry zero to eight data bytes.
// - A PGN-only request is sent with the loaded header bytes, the global-request header after reset.
// - After sending a request the block listens and prints every matching frame.
// - The header-set command loads header bytes used by all later requests.
// - No address claiming; the source address always comes from the header bytes.
// - Request bytes are reversed before sending by default; a toggle disables it.
// - Transport handshakes run silently; only the response content is printed.
// - A three-byte request is a PGN; only responses to that PGN are accepted.
// - Other byte counts accept responses addressed to the header source address.
// - The fault broadcast monitor prints every trouble-code broadcast on the bus.
// - The PGN monitor prints every received frame carrying the given PGN.
// - A four-digit PGN monitor argument gets two leading zero digits.
// - Any listening or monitoring stops when the host sends a character.
// - Formatting is on by default; off prints raw identifier bytes then data.
// - Formatted lines start with the priority as one hex digit.
// - The data page digit precedes the four PGN digits; reserved bit is hidden.
// - The sender source address byte follows the PGN field.
// - With formatting and length display on, one length digit follows the source address.
// - Exactly the received data bytes are printed, fewer than eight allowed.
package hvf_pkg;
	// ==========================================================
	// Register map and fields
	localparam logic [7:0] HVF_ADDR_CFG = 8'h00;
	localparam logic [7:0] HVF_ADDR_BITRATE = 8'h04;
	localparam logic [7:0] HVF_ADDR_HEADER = 8'h08;
	localparam logic [7:0] HVF_ADDR_MON_PGN = 8'h0C;
	localparam logic [7:0] HVF_ADDR_CMD = 8'h10;
	localparam logic [7:0] HVF_ADDR_STATUS = 8'h14;
	localparam int HVF_CFG_FMT_BIT = 0;
	localparam int HVF_CFG_REV_BIT = 1;
	localparam int HVF_CFG_LEN_BIT = 2;
	localparam int HVF_CFG_PROTO_LSB = 4;
	localparam int HVF_CFG_UB_BIT = 6;
	localparam int HVF_CFG_UC_BIT = 7;
	localparam int HVF_MON_SHORT_BIT = 31;
	localparam logic [7:0] HVF_CFG_RESET = 8'h03;
	localparam logic [15:0] HVF_BITRATE_RESET_KBPS = 16'h00FA;
	localparam logic [23:0] HVF_HEADER_RESET = 24'hEAFFF9;
	localparam logic [1:0] HVF_PROTO_HEAVY = 2'h0;
	localparam logic [1:0] HVF_PROTO_USER_B = 2'h1;
	localparam logic [1:0] HVF_PROTO_USER_C = 2'h2;
	// ==========================================================
	// Commands written to the command register
	localparam logic [7:0] HVF_CMD_FAULT_MON = 8'h01;
	localparam logic [7:0] HVF_CMD_PGN_MON = 8'h02;
	localparam logic [7:0] HVF_CMD_STOP = 8'h03;
	localparam logic [7:0] HVF_CMD_CLR_ERR = 8'h04;
	// ==========================================================
	// Protocol constants
	localparam logic [2:0] HVF_TX_PRIO = 3'h6;
	localparam logic [2:0] HVF_TP_PRIO = 3'h7;
	localparam logic [23:0] HVF_FAULT_PGN = 24'h00FECA;
	localparam logic [7:0] HVF_PDU2_MIN = 8'hF0;
	localparam logic [7:0] HVF_GLOBAL_SA = 8'hFF;
	localparam logic [7:0] HVF_TP_CM_PF = 8'hEC;
	localparam logic [7:0] HVF_TP_DT_PF = 8'hEB;
	localparam logic [7:0] HVF_TP_RTS = 8'h10;
	localparam logic [7:0] HVF_TP_CTS = 8'h11;
	localparam logic [7:0] HVF_TP_ACK = 8'h13;
	localparam logic [7:0] HVF_TP_BAM = 8'h20;
	localparam logic [3:0] HVF_PGN_REQ_LEN = 4'h3;
	localparam logic [3:0] HVF_MAX_DATA = 4'h8;
	localparam logic [15:0] HVF_TP_SEG = 16'h0007;
	localparam logic [7:0] HVF_CHAR_CR = 8'h0D;
	localparam logic [7:0] HVF_CHAR_SP = 8'h20;
	localparam int HVF_LINE_NIBS = 25;
	// ==========================================================
	// State types
	typedef enum logic [1:0] {
		HVF_MODE_IDLE = 2'b00,
		HVF_MODE_SEND = 2'b01,
		HVF_MODE_LISTEN = 2'b11,
		HVF_MODE_MON = 2'b10
	} hvf_mode_t;
	typedef enum logic [1:0] {
		HVF_TP_IDLE = 2'b00,
		HVF_TP_SEND_CTS = 2'b01,
		HVF_TP_RECV = 2'b11,
		HVF_TP_SEND_ACK = 2'b10
	} hvf_tp_t;
endpackage

// ==== hw/hvf_formatter.sv ====
// Heavy-vehicle CAN request formatter: requests, filtering, transport and line printing.
`timescale 1ns/1ps
`default_nettype none
module hvf_formatter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Host request bytes and host keystroke
	input wire logic req_valid,
	input wire logic [7:0] req_byte,
	input wire logic req_last,
	input wire logic host_char,
	// CAN transmit frame
	output logic tx_valid,
	output logic [28:0] tx_id,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	input wire logic tx_ready,
	// CAN received frame
	input wire logic rx_valid,
	input wire logic [28:0] rx_id,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	// Printed characters
	output logic ch_valid,
	output logic [7:0] ch_data,
	input wire logic ch_ready,
	// Bit rate for the CAN controller
	output logic [15:0] bitrate_kbps
);
	import hvf_pkg::*;

	function automatic logic [23:0] pgn_of(input logic [28:0] id);
		pgn_of = {6'h00, id[25], id[24], id[23:16], (id[23:16] >= HVF_PDU2_MIN) ? id[15:8] : 8'h00};
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// ==========================================================
	// Registers
	logic [7:0] cfg_q;
	logic [15:0] bitrate_q;
	logic [23:0] hdr_q;
	logic [23:0] mon_arg_q;
	logic [23:0] mon_pgn_q;
	logic [31:0] rdata_q;
	logic err_q;
	hvf_mode_t mode_q;
	hvf_tp_t tp_q;
	logic pbusy_q;
	logic wr_cfg, wr_cmd, cmd_fault, cmd_pgn, cmd_stop, cmd_clr;
	logic fmt_on, rev_on, len_on, heavy_on;

	assign wr_cfg = reg_wr && (reg_addr == HVF_ADDR_CFG);
	assign wr_cmd = reg_wr && (reg_addr == HVF_ADDR_CMD);
	assign cmd_fault = wr_cmd && (reg_wdata[7:0] == HVF_CMD_FAULT_MON);
	assign cmd_pgn = wr_cmd && (reg_wdata[7:0] == HVF_CMD_PGN_MON);
	assign cmd_stop = wr_cmd && (reg_wdata[7:0] == HVF_CMD_STOP);
	assign cmd_clr = wr_cmd && (reg_wdata[7:0] == HVF_CMD_CLR_ERR);
	assign fmt_on = cfg_q[HVF_CFG_FMT_BIT];
	assign rev_on = cfg_q[HVF_CFG_REV_BIT];
	assign len_on = cfg_q[HVF_CFG_LEN_BIT];
	assign heavy_on = (cfg_q[HVF_CFG_PROTO_LSB+:2] == HVF_PROTO_HEAVY)
		|| ((cfg_q[HVF_CFG_PROTO_LSB+:2] == HVF_PROTO_USER_B) && cfg_q[HVF_CFG_UB_BIT])
		|| ((cfg_q[HVF_CFG_PROTO_LSB+:2] == HVF_PROTO_USER_C) && cfg_q[HVF_CFG_UC_BIT]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= HVF_CFG_RESET;
			bitrate_q <= HVF_BITRATE_RESET_KBPS;
			hdr_q <= HVF_HEADER_RESET;
			mon_arg_q <= '0;
			mon_pgn_q <= HVF_FAULT_PGN;
		end else begin
			if (wr_cfg) begin
				cfg_q <= reg_wdata[7:0];
			end
			if (reg_wr && (reg_addr == HVF_ADDR_BITRATE)) begin
				bitrate_q <= reg_wdata[15:0];
			end
			if (reg_wr && (reg_addr == HVF_ADDR_HEADER)) begin
				hdr_q <= reg_wdata[23:0];
			end
			if (reg_wr && (reg_addr == HVF_ADDR_MON_PGN)) begin
				mon_arg_q <= reg_wdata[HVF_MON_SHORT_BIT] ? {8'h00, reg_wdata[15:0]} : reg_wdata[23:0];
			end
			if (cmd_fault) begin
				mon_pgn_q <= HVF_FAULT_PGN;
			end else if (cmd_pgn) begin
				mon_pgn_q <= mon_arg_q;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				HVF_ADDR_CFG: rdata_q <= {24'h0, cfg_q};
				HVF_ADDR_BITRATE: rdata_q <= {16'h0, bitrate_q};
				HVF_ADDR_HEADER: rdata_q <= {8'h0, hdr_q};
				HVF_ADDR_MON_PGN: rdata_q <= {8'h0, mon_pgn_q};
				HVF_ADDR_STATUS: rdata_q <= {26'h0, err_q, pbusy_q, tp_q, mode_q};
				default: rdata_q <= '0;
			endcase
		end
	end

	// ==========================================================
	// Request intake
	logic [7:0] req_buf_q [0:7];
	logic [3:0] req_cnt_q;
	logic [3:0] req_n_q;
	logic req_ovf_q, req_go_q, req3_q;
	logic [23:0] req_pgn_q;
	logic req_end, req_bad, req_ok, load_tp, load_req;
	logic tx_req_q;

	assign req_end = req_valid && req_last;
	assign req_bad = req_end && (req_ovf_q || (req_cnt_q == HVF_MAX_DATA) || !heavy_on);
	assign req_ok = req_end && !req_bad;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_buf_q <= '{default: 8'h00};
			req_cnt_q <= '0;
			req_n_q <= '0;
			req_ovf_q <= 1'b0;
			req_go_q <= 1'b0;
			req3_q <= 1'b0;
			req_pgn_q <= '0;
		end else begin
			if (req_valid) begin
				if (req_cnt_q < HVF_MAX_DATA) begin
					req_buf_q[req_cnt_q[2:0]] <= req_byte;
					req_cnt_q <= req_cnt_q + 4'h1;
				end else begin
					req_ovf_q <= 1'b1;
				end
			end
			if (req_end) begin
				req_cnt_q <= '0;
				req_ovf_q <= 1'b0;
			end
			if (req_ok) begin
				req_n_q <= req_cnt_q + 4'h1;
				req3_q <= (req_cnt_q + 4'h1) == HVF_PGN_REQ_LEN;
				req_pgn_q <= {req_buf_q[0], req_buf_q[1], req_byte};
			end
			if (req_ok) begin
				req_go_q <= 1'b1;
			end else if (load_req) begin
				req_go_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= 1'b0;
		end else if (req_bad) begin
			err_q <= 1'b1;
		end else if (cmd_clr) begin
			err_q <= 1'b0;
		end
	end

	// ==========================================================
	// Transport session
	logic [23:0] tp_pgn_q;
	logic [7:0] tp_sa_q, tp_npk_q;
	logic [15:0] tp_size_q, tp_left_q;
	logic tp_bam_q;
	logic [23:0] rx_pgn, cm_pgn;
	logic is_cm, is_dt, cm_match, start_tp, match_req, print_plain, cap_go;
	logic [3:0] dt_n;
	logic [7:0] our_sa;

	assign our_sa = hdr_q[7:0];
	assign rx_pgn = pgn_of(rx_id);
	assign cm_pgn = {rx_data[63:56], rx_data[55:48], rx_data[47:40]};
	assign is_cm = (rx_id[23:16] == HVF_TP_CM_PF)
		&& ((rx_id[15:8] == our_sa) || (rx_id[15:8] == HVF_GLOBAL_SA));
	assign is_dt = rx_valid && (rx_id[23:16] == HVF_TP_DT_PF) && (rx_id[7:0] == tp_sa_q)
		&& (tp_q == HVF_TP_RECV);
	assign match_req = req3_q ? (rx_pgn == req_pgn_q)
		: ((rx_id[23:16] < HVF_PDU2_MIN) && (rx_id[15:8] == our_sa));
	assign cm_match = req3_q ? (cm_pgn == req_pgn_q) : (rx_id[15:8] == our_sa);
	assign start_tp = rx_valid && is_cm && cm_match && (mode_q == HVF_MODE_LISTEN)
		&& (tp_q == HVF_TP_IDLE) && ((rx_data[7:0] == HVF_TP_RTS) || (rx_data[7:0] == HVF_TP_BAM));
	assign dt_n = (tp_left_q > HVF_TP_SEG) ? 4'h7 : tp_left_q[3:0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tp_q <= HVF_TP_IDLE;
			tp_pgn_q <= '0;
			tp_sa_q <= '0;
			tp_npk_q <= '0;
			tp_size_q <= '0;
			tp_left_q <= '0;
			tp_bam_q <= 1'b0;
		end else if (mode_q != HVF_MODE_LISTEN) begin
			tp_q <= HVF_TP_IDLE;
		end else begin
			unique case (tp_q)
				HVF_TP_IDLE: if (start_tp) begin
					tp_pgn_q <= cm_pgn;
					tp_sa_q <= rx_id[7:0];
					tp_npk_q <= rx_data[31:24];
					tp_size_q <= rx_data[23:8];
					tp_left_q <= rx_data[23:8];
					tp_bam_q <= rx_data[7:0] == HVF_TP_BAM;
					tp_q <= (rx_data[7:0] == HVF_TP_BAM) ? HVF_TP_RECV : HVF_TP_SEND_CTS;
				end
				HVF_TP_SEND_CTS: if (load_tp) begin
					tp_q <= HVF_TP_RECV;
				end
				HVF_TP_RECV: if (is_dt) begin
					tp_left_q <= tp_left_q - {12'h0, dt_n};
					if (tp_left_q <= HVF_TP_SEG) begin
						tp_q <= tp_bam_q ? HVF_TP_IDLE : HVF_TP_SEND_ACK;
					end
				end
				HVF_TP_SEND_ACK: if (load_tp) begin
					tp_q <= HVF_TP_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Transmit frame register
	logic tx_valid_q;
	logic [28:0] tx_id_q;
	logic [3:0] tx_dlc_q;
	logic [63:0] tx_data_q;
	logic [63:0] req_frame;
	logic [7:0] tp_ctl;

	assign load_tp = !tx_valid_q && ((tp_q == HVF_TP_SEND_CTS) || (tp_q == HVF_TP_SEND_ACK));
	assign load_req = !tx_valid_q && !load_tp && req_go_q;
	assign tp_ctl = (tp_q == HVF_TP_SEND_CTS) ? HVF_TP_CTS : HVF_TP_ACK;

	always_comb begin
		req_frame = '0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(req_n_q)) begin
				req_frame[8*i+:8] = rev_on ? req_buf_q[3'(int'(req_n_q) - 1 - i)] : req_buf_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_id_q <= '0;
			tx_dlc_q <= '0;
			tx_data_q <= '0;
			tx_req_q <= 1'b0;
		end else if (load_tp) begin
			tx_valid_q <= 1'b1;
			tx_id_q <= {HVF_TP_PRIO, 2'b00, HVF_TP_CM_PF, tp_sa_q, our_sa};
			tx_dlc_q <= HVF_MAX_DATA;
			tx_data_q <= {tp_pgn_q[23:16], tp_pgn_q[15:8], tp_pgn_q[7:0], 8'hFF,
				(tp_q == HVF_TP_SEND_CTS) ? {8'hFF, 8'h01, tp_npk_q} : {tp_npk_q, tp_size_q},
				tp_ctl};
			tx_req_q <= 1'b0;
		end else if (load_req) begin
			tx_valid_q <= 1'b1;
			tx_id_q <= {HVF_TX_PRIO, 2'b00, hdr_q};
			tx_dlc_q <= req_n_q;
			tx_data_q <= req_frame;
			tx_req_q <= 1'b1;
		end else if (tx_valid_q && tx_ready) begin
			tx_valid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Operating mode
	logic tx_req_done;
	assign tx_req_done = tx_valid_q && tx_ready && tx_req_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= HVF_MODE_IDLE;
		end else if (req_ok) begin
			mode_q <= HVF_MODE_SEND;
		end else if (host_char || cmd_stop) begin
			mode_q <= HVF_MODE_IDLE;
		end else if (cmd_fault || cmd_pgn) begin
			mode_q <= HVF_MODE_MON;
		end else if ((mode_q == HVF_MODE_SEND) && tx_req_done) begin
			mode_q <= HVF_MODE_LISTEN;
		end
	end

	// ==========================================================
	// Line capture and printing
	logic [28:0] cap_id;
	logic [3:0] cap_n;
	logic [63:0] cap_data;
	logic [3:0] cap_nib [0:HVF_LINE_NIBS-1];
	logic [HVF_LINE_NIBS-1:0] cap_sep;
	logic [4:0] cap_len;
	logic [3:0] pn_q [0:HVF_LINE_NIBS-1];
	logic [HVF_LINE_NIBS-1:0] psep_q;
	logic [4:0] plen_q, pidx_q;
	logic pspc_q, char_adv, ch_valid_q;
	logic [7:0] ch_data_q;

	assign print_plain = rx_valid && heavy_on && !(is_cm || (rx_id[23:16] == HVF_TP_DT_PF))
		&& (((mode_q == HVF_MODE_LISTEN) && match_req)
		|| ((mode_q == HVF_MODE_MON) && (rx_pgn == mon_pgn_q)));
	assign cap_go = !pbusy_q && (print_plain || is_dt);
	assign cap_id = is_dt ? {rx_id[28:26], tp_pgn_q[17:0], tp_sa_q} : rx_id;
	assign cap_data = is_dt ? {8'h00, rx_data[63:8]} : rx_data;
	assign cap_n = is_dt ? dt_n : ((rx_dlc > HVF_MAX_DATA) ? HVF_MAX_DATA : rx_dlc);

	always_comb begin
		int k;
		k = 8;
		cap_nib = '{default: 4'h0};
		cap_sep = '0;
		if (fmt_on) begin
			cap_nib[0] = {1'b0, cap_id[28:26]};
			cap_sep[0] = 1'b1;
			// page digit then PGN, reserved bit dropped
			cap_nib[1] = {3'b000, cap_id[24]};
			cap_nib[2] = cap_id[23:20];
			cap_nib[3] = cap_id[19:16];
			cap_nib[4] = cap_id[15:12];
			cap_nib[5] = cap_id[11:8];
			cap_sep[5] = 1'b1;
			cap_nib[6] = cap_id[7:4];
			cap_nib[7] = cap_id[3:0];
			cap_sep[7] = 1'b1;
			if (len_on) begin
				cap_nib[8] = cap_n;
				cap_sep[8] = 1'b1;
				k = 9;
			end
		end else begin
			cap_nib[0] = {3'b000, cap_id[28]};
			cap_nib[1] = cap_id[27:24];
			cap_nib[2] = cap_id[23:20];
			cap_nib[3] = cap_id[19:16];
			cap_nib[4] = cap_id[15:12];
			cap_nib[5] = cap_id[11:8];
			cap_nib[6] = cap_id[7:4];
			cap_nib[7] = cap_id[3:0];
			cap_sep[1] = 1'b1;
			cap_sep[3] = 1'b1;
			cap_sep[5] = 1'b1;
			cap_sep[7] = 1'b1;
		end
		for (int j = 0; j < 8; j++) begin
			if (j < int'(cap_n)) begin
				cap_nib[k] = cap_data[8*j+4+:4];
				cap_nib[k+1] = cap_data[8*j+:4];
				cap_sep[k+1] = 1'b1;
				k = k + 2;
			end
		end
		cap_len = 5'(k);
	end

	assign char_adv = pbusy_q && (!ch_valid_q || ch_ready);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pn_q <= '{default: 4'h0};
			psep_q <= '0;
			plen_q <= '0;
			pidx_q <= '0;
			pspc_q <= 1'b0;
			pbusy_q <= 1'b0;
		end else if (cap_go) begin
			pn_q <= cap_nib;
			psep_q <= cap_sep;
			plen_q <= cap_len;
			pidx_q <= '0;
			pspc_q <= 1'b0;
			pbusy_q <= 1'b1;
		end else if (char_adv) begin
			if (pspc_q) begin
				pspc_q <= 1'b0;
				pidx_q <= pidx_q + 5'h01;
			end else if (pidx_q == plen_q) begin
				pbusy_q <= 1'b0;
			end else if (psep_q[pidx_q] && ((pidx_q + 5'h01) != plen_q)) begin
				pspc_q <= 1'b1;
			end else begin
				pidx_q <= pidx_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_valid_q <= 1'b0;
			ch_data_q <= '0;
		end else if (char_adv) begin
			ch_valid_q <= 1'b1;
			ch_data_q <= pspc_q ? HVF_CHAR_SP
				: ((pidx_q == plen_q) ? HVF_CHAR_CR : hex_char(pn_q[pidx_q]));
		end else if (ch_ready) begin
			ch_valid_q <= 1'b0;
		end
	end

	assign reg_rdata = rdata_q;
	assign tx_valid = tx_valid_q;
	assign tx_id = tx_id_q;
	assign tx_dlc = tx_dlc_q;
	assign tx_data = tx_data_q;
	assign ch_valid = ch_valid_q;
	assign ch_data = ch_data_q;
	assign bitrate_kbps = bitrate_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_rev_pgn;
		load_req && rev_on && (req_n_q == HVF_PGN_REQ_LEN) |=>
			(tx_data_q[7:0] == $past(req_buf_q[2])) && (tx_data_q[23:16] == $past(req_buf_q[0]));
	endproperty
	a_rev_pgn: assert property (p_rev_pgn) else $error("request bytes not reversed");

	property p_len;
		load_req |=> tx_valid_q && (tx_dlc_q == $past(req_n_q)) && (tx_dlc_q <= HVF_MAX_DATA);
	endproperty
	a_len: assert property (p_len) else $error("request length wrong");

	property p_hdr;
		load_req |=> (tx_id_q[23:0] == $past(hdr_q)) && (tx_id_q[28:26] == HVF_TX_PRIO);
	endproperty
	a_hdr: assert property (p_hdr) else $error("header bytes not used");

	property p_listen;
		(mode_q == HVF_MODE_SEND) && tx_req_done && !req_ok && !host_char && !wr_cmd
			|=> mode_q == HVF_MODE_LISTEN;
	endproperty
	a_listen: assert property (p_listen) else $error("no listen after send");

	property p_oversize;
		req_end && (req_cnt_q == HVF_MAX_DATA) |=> err_q && !req_go_q [*2];
	endproperty
	a_oversize: assert property (p_oversize) else $error("oversize request sent");

	property p_stop;
		host_char && !req_ok |=> (mode_q == HVF_MODE_IDLE) ##1 (tp_q == HVF_TP_IDLE);
	endproperty
	a_stop: assert property (p_stop) else $error("keystroke did not stop");

	property p_prio;
		cap_go && fmt_on |=> (pn_q[0] == {1'b0, $past(cap_id[28:26])}) && psep_q[0];
	endproperty
	a_prio: assert property (p_prio) else $error("priority digit wrong");

	property p_fault;
		cmd_fault && !req_ok && !host_char |=> (mon_pgn_q == HVF_FAULT_PGN) && (mode_q == HVF_MODE_MON);
	endproperty
	a_fault: assert property (p_fault) else $error("fault monitor not armed");

	sequence s_cts_wait;
		tp_q == HVF_TP_SEND_CTS;
	endsequence
	sequence s_cts_out;
		tx_valid_q && (tx_data_q[7:0] == HVF_TP_CTS);
	endsequence
	property p_cts;
		start_tp && (rx_data[7:0] == HVF_TP_RTS) |=> s_cts_wait ##[1:300] s_cts_out;
	endproperty
	a_cts: assert property (p_cts) else $error("clear to send missing");
endmodule
`default_nettype wire

// ==== tb/hvf_can_node.sv ====
// Far-side model: CAN controller and nodes that take frames and reply.
`timescale 1ns/1ps
`default_nettype none
module hvf_can_node (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Frames to the bus
	input wire logic tx_valid,
	input wire logic [28:0] tx_id,
	input wire logic [3:0] tx_dlc,
	input wire logic [63:0] tx_data,
	output logic tx_ready,
	// Frames from the bus
	output logic rx_valid,
	output logic [28:0] rx_id,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data
);
	integer seed = 59;
	int n_tx = 0;
	logic [28:0] got_id;
	logic [3:0] got_dlc;
	logic [63:0] got_data;
	initial begin
		rx_valid = 1'b0;
		rx_id = '0;
		rx_dlc = '0;
		rx_data = '0;
	end
	// Random stalls give both prompt and slow acceptance.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
		end else begin
			if (tx_valid && tx_ready) begin
				got_id <= tx_id;
				got_dlc <= tx_dlc;
				got_data <= tx_data;
				n_tx <= n_tx + 1;
			end
			tx_ready <= ($random(seed) % 3) == 0;
		end
	end
	task automatic send(input logic [28:0] id, input logic [3:0] n, input logic [63:0] d);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_dlc <= n;
		rx_data <= d;
		@(posedge clk);
		// Stale fields would hide a late sample, so they flip after the pulse.
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_dlc <= ~n;
		rx_data <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== tb/hvf_formatter_tb.sv ====
// Self-checking bench of the heavy-vehicle CAN request formatter.
`timescale 1ns/1ps
`default_nettype none
module hvf_formatter_tb;
	import hvf_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, req_valid, req_last, host_char, ch_ready;
	logic tx_valid, tx_ready, rx_valid, ch_valid;
	logic [7:0] reg_addr, req_byte, ch_data;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [28:0] tx_id, rx_id;
	logic [3:0] tx_dlc, rx_dlc;
	logic [63:0] tx_data, rx_data, d;
	logic [15:0] bitrate_kbps, b;
	logic [7:0] rq [0:8];
	integer seed = 59;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n0;
	string s;
	hvf_formatter i_dut (.*);
	hvf_can_node i_node (.*);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================
	// Printer stalls and hang guard
	always @(posedge clk) begin
		ch_ready <= ($random(seed) % 4) != 0;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// ==========================================
	// Tasks
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic chks(input string nm, input string e, input string g);
		n_tests++;
		if (g != e) begin
			$display("unexpected %s: expected %s seen %s", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		x = reg_rdata;
	endtask
	task automatic send_req(input int n);
		for (int i = 0; i < n; i++) begin
			req_valid <= 1'b1;
			req_byte <= rq[i];
			req_last <= (i == n - 1);
			@(posedge clk);
		end
		req_valid <= 1'b0;
		req_last <= 1'b0;
	endtask
	task automatic wait_tx(input int n);
		for (int k = 0; k < 100 && i_node.n_tx == n; k++) @(posedge clk);
		chk("tx taken", n + 1, i_node.n_tx);
	endtask
	task automatic host_stop;
		host_char <= 1'b1;
		@(posedge clk);
		host_char <= 1'b0;
		repeat (3) @(posedge clk);
		rd(HVF_ADDR_STATUS, v);
		chk("mode", 2'b00, v[1:0]);
	endtask
	task automatic get_line(output string t);
		string c;
		t = "";
		c = "?";
		for (int k = 0; k < 400; k++) begin
			@(posedge clk);
			if (ch_valid === 1'b1 && ch_ready === 1'b1) begin
				if (ch_data === HVF_CHAR_CR) break;
				c[0] = ch_data;
				t = {t, c};
			end
		end
	endtask
	function automatic string hn(logic [3:0] x);
		string c;
		c = "0";
		c[0] = (x < 4'hA) ? 8'h30 + x : 8'h37 + x;
		return c;
	endfunction
	function automatic string hb(logic [7:0] x);
		return {hn(x[7:4]), hn(x[3:0])};
	endfunction
	function automatic string exp_line(logic [28:0] id, logic [3:0] n, logic [63:0] x, bit raw,
			bit len);
		string t;
		logic [31:0] w;
		w = {3'h0, id};
		if (raw) t = {hb(w[31:24]), " ", hb(w[23:16]), " ", hb(w[15:8]), " ", hb(w[7:0])};
		else t = {hn(w[28:26]), " ", hn(w[24]), hb(w[23:16]), hb(w[15:8]), " ", hb(w[7:0])};
		if (len) t = {t, " ", hn(n)};
		for (int i = 0; i < n; i++) t = {t, " ", hb(x[8*i+:8])};
		return t;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, req_valid, req_last, host_char} = '0;
		{reg_addr, req_byte, reg_wdata} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(HVF_ADDR_CFG, v);
		chk("cfg", HVF_CFG_RESET, v);
		rd(HVF_ADDR_HEADER, v);
		chk("header", 24'hEAFFF9, v);
		rd(8'hFC, v);
		chk("unmapped", 32'h0, v);
		chk("bitrate", 16'h00FA, bitrate_kbps);
		b = 16'($random(seed));
		wr(HVF_ADDR_BITRATE, {16'h0, b});
		repeat (2) @(posedge clk);
		chk("bitrate", b, bitrate_kbps);
		$display("test reset done");
		rq[0] = 8'h00;
		rq[1] = 8'hFE;
		rq[2] = 8'hEE;
		n0 = i_node.n_tx;
		send_req(3);
		wait_tx(n0);
		chk("tx id", {HVF_TX_PRIO, 2'b00, 24'hEAFFF9}, i_node.got_id);
		chk("tx dlc", 4'h3, i_node.got_dlc);
		chk("tx data", 24'h00FEEE, i_node.got_data);
		rd(HVF_ADDR_STATUS, v);
		chk("mode", 2'b11, v[1:0]);
		d = {$random(seed), $random(seed)};
		i_node.send(29'h18FEF100, 4'h8, d);
		repeat (4) @(posedge clk);
		i_node.send(29'h18FEEE00, 4'h2, d);
		get_line(s);
		chks("pgn reply", exp_line(29'h18FEEE00, 4'h2, d, 1'b0, 1'b0), s);
		n0 = i_node.n_tx;
		i_node.send(29'h1CECF900, 4'h8, 64'h00FEEEFF02000910);
		wait_tx(n0);
		chk("cts id", 29'h1CEC00F9, i_node.got_id);
		chk("cts data", 64'h00FEEEFFFF010211, i_node.got_data);
		i_node.send(29'h1CEBF900, 4'h8, {d[55:0], 8'h01});
		get_line(s);
		chks("segment 1", exp_line(29'h1CFEEE00, 4'h7, d, 1'b0, 1'b0), s);
		i_node.send(29'h1CEBF900, 4'h8, {d[55:0], 8'h02});
		get_line(s);
		chks("segment 2", exp_line(29'h1CFEEE00, 4'h2, d, 1'b0, 1'b0), s);
		wait_tx(n0 + 1);
		chk("ack data", 64'h00FEEEFF02000913, i_node.got_data);
		host_stop();
		$display("test pgn request done");
		wr(HVF_ADDR_HEADER, 32'h00EA00F9);
		wr(HVF_ADDR_CFG, 32'h05);
		rq[0] = 8'($random(seed));
		rq[1] = 8'($random(seed));
		n0 = i_node.n_tx;
		send_req(2);
		wait_tx(n0);
		chk("tx id", {HVF_TX_PRIO, 2'b00, 24'hEA00F9}, i_node.got_id);
		chk("tx data", {rq[1], rq[0]}, i_node.got_data);
		i_node.send(29'h18EF3300, 4'h5, d);
		repeat (4) @(posedge clk);
		i_node.send(29'h18EFF900, 4'h5, d);
		get_line(s);
		chks("sa reply", exp_line(29'h18EFF900, 4'h5, d, 1'b0, 1'b1), s);
		host_stop();
		$display("test general request done");
		for (int i = 0; i < 9; i++) rq[i] = 8'($random(seed));
		n0 = i_node.n_tx;
		send_req(9);
		repeat (10) @(posedge clk);
		rd(HVF_ADDR_STATUS, v);
		chk("error", 1'b1, v[5]);
		chk("tx count", n0, i_node.n_tx);
		wr(HVF_ADDR_CMD, HVF_CMD_CLR_ERR);
		rd(HVF_ADDR_STATUS, v);
		chk("error", 1'b0, v[5]);
		wr(HVF_ADDR_CFG, 32'h13);
		send_req(3);
		repeat (2) @(posedge clk);
		rd(HVF_ADDR_STATUS, v);
		chk("error", 1'b1, v[5]);
		chk("tx count", n0, i_node.n_tx);
		wr(HVF_ADDR_CMD, HVF_CMD_CLR_ERR);
		$display("test long request done");
		wr(HVF_ADDR_CFG, 32'h02);
		wr(HVF_ADDR_CMD, HVF_CMD_FAULT_MON);
		d = {$random(seed), $random(seed)};
		i_node.send(29'h18FECA00, 4'h8, d);
		get_line(s);
		chks("raw fault", exp_line(29'h18FECA00, 4'h8, d, 1'b1, 1'b0), s);
		host_stop();
		wr(HVF_ADDR_MON_PGN, 32'h8000FECB);
		wr(HVF_ADDR_CFG, 32'h03);
		wr(HVF_ADDR_CMD, HVF_CMD_PGN_MON);
		rd(HVF_ADDR_MON_PGN, v);
		chk("monitor pgn", 24'h00FECB, v);
		i_node.send(29'h18FECA00, 4'h8, d);
		repeat (4) @(posedge clk);
		i_node.send(29'h18FECB07, 4'h3, d);
		get_line(s);
		chks("pgn monitor", exp_line(29'h18FECB07, 4'h3, d, 1'b0, 1'b0), s);
		wr(HVF_ADDR_CMD, HVF_CMD_STOP);
		rd(HVF_ADDR_STATUS, v);
		chk("mode", 2'b00, v[1:0]);
		host_stop();
		$display("test monitors done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
